// >>> dpsem_cfg.svh
// Timing counts and pin constants for the semaphore port controller
`ifndef DPSEM_CFG_SVH
`define DPSEM_CFG_SVH

`define DPSEM_CLK_PERIOD_NS  10
`define DPSEM_SETUP_NS       20
`define DPSEM_SETUP_CYC      ((`DPSEM_SETUP_NS + `DPSEM_CLK_PERIOD_NS - 1) / `DPSEM_CLK_PERIOD_NS)
`define DPSEM_STROBE_NS      30
`define DPSEM_STROBE_CYC     ((`DPSEM_STROBE_NS + `DPSEM_CLK_PERIOD_NS - 1) / `DPSEM_CLK_PERIOD_NS)
`define DPSEM_GAP_NS         20
`define DPSEM_GAP_CYC        ((`DPSEM_GAP_NS + `DPSEM_CLK_PERIOD_NS - 1) / `DPSEM_CLK_PERIOD_NS)
`define DPSEM_TOKEN_COUNT    8
`define DPSEM_IDX_W          3
`define DPSEM_DATA_W         8
`define DPSEM_CNT_W          4
`define DPSEM_TOKEN_BIT      0

`endif

// >>> dpsem_pkg.sv
// Types for the semaphore port controller
package dpsem_pkg;
  typedef enum logic [1:0] {
    DPSEM_OP_INIT,
    DPSEM_OP_CLAIM,
    DPSEM_OP_RELEASE,
    DPSEM_OP_POLL
  } dpsem_op_t;

  typedef enum {
    DPSEM_IDLE,
    DPSEM_WR_SETUP,
    DPSEM_WR_STROBE,
    DPSEM_WR_GAP,
    DPSEM_RD_SETUP,
    DPSEM_RD_STROBE,
    DPSEM_RD_GAP,
    DPSEM_DONE
  } dpsem_state_t;
endpackage

// >>> dpsem_sync.sv
// Two-flop synchroniser for the data bus returning from the memory
`timescale 1ns/1ps
`include "dpsem_cfg.svh"

module dpsem_sync (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // Data
  input  wire logic [`DPSEM_DATA_W-1:0] d_in,
  output logic      [`DPSEM_DATA_W-1:0] d_out
);
  logic [`DPSEM_DATA_W-1:0] stage_reg;
  logic [`DPSEM_DATA_W-1:0] out_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_reg <= '1;
      out_reg   <= '1;
    end else begin
      stage_reg <= d_in;
      out_reg   <= stage_reg;
    end
  end

  assign d_out = out_reg;
endmodule

// >>> dpsem_ctrl.sv
// Host-side controller driving one port of a dual-port semaphore block
`timescale 1ns/1ps
`include "dpsem_cfg.svh"

// Notes on behaviour
// [R1] The device holds eight token latches apart from its memory array.
// [R2] Tokens active low: write zero to request, write one to release.
// [R3] Token space selected by select low; address, enable, write as plain memory.
// [R4] Only the three lowest address bits pick the latch.
// [R5] Only data bit zero carries the written token.
// [R6] Zero to a free token: owner reads zero, other port reads one.
// [R7] Owner writing one frees the token unless the other side waits.
// [R8] A non-owner zero stays pending; that port reads one meanwhile.
// [R9] Pending request gains ownership at once when owner releases.
// [R10] Reads spread the flag over every data bit.
// [R11] Read value is captured when select and output enable go active.
// [R12] Drop select or output enable between successive reads.
// [R13] Claim by writing zero first, then read back to confirm.
// [R14] After failure, keep rereading or write one to withdraw.
// [R15] Simultaneous requests grant exactly one port.
// [R16] At start, software writes one to all eight tokens.
// [R17] Hold memory chip enable high while select is low.
// [R18] Latch state is unknown until written; no reset frees tokens.
module dpsem_ctrl (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // Command side
  input  wire logic                     cmd_valid,
  input  wire dpsem_pkg::dpsem_op_t     cmd_op,
  input  wire logic [`DPSEM_IDX_W-1:0]  cmd_index,
  output logic                          cmd_ready,
  output logic                          rsp_valid,
  output logic                          rsp_owned,
  // Device pins of one port
  output logic                          token_space_select_n,
  output logic                          mem_enable_n,
  output logic                          write_n,
  output logic                          out_enable_n,
  output logic [`DPSEM_IDX_W-1:0]       token_index,
  output logic [`DPSEM_DATA_W-1:0]      data_out,
  output logic                          data_oe,
  input  wire logic [`DPSEM_DATA_W-1:0] data_in
);
  dpsem_pkg::dpsem_state_t  state_reg, state_next;
  dpsem_pkg::dpsem_op_t     op_reg, op_next;
  logic [`DPSEM_CNT_W-1:0]  cnt_reg, cnt_next;
  logic [`DPSEM_IDX_W-1:0]  idx_reg, idx_next;
  logic                     init_last_reg, init_last_next;
  logic                     sel_n_reg, sel_n_next;
  logic                     we_n_reg, we_n_next;
  logic                     oe_n_reg, oe_n_next;
  logic                     doe_reg, doe_next;
  logic                     dbit_reg, dbit_next;
  logic                     ready_reg, ready_next;
  logic                     rsp_reg, rsp_next;
  logic                     owned_reg, owned_next;
  logic [`DPSEM_DATA_W-1:0] rd_sync;

  // Token bit value written: zero requests, one releases or withdraws
  function automatic logic token_wr_value(input dpsem_pkg::dpsem_op_t op);
    token_wr_value = (op == dpsem_pkg::DPSEM_OP_CLAIM) ? 1'b0 : 1'b1;
  endfunction

  function automatic logic [`DPSEM_CNT_W-1:0] cyc(input int n);
    cyc = `DPSEM_CNT_W'(n - 1);
  endfunction

  dpsem_sync u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d_in  (data_in),
    .d_out (rd_sync)
  );

  always_comb begin
    state_next     = state_reg;
    op_next        = op_reg;
    cnt_next       = cnt_reg;
    idx_next       = idx_reg;
    init_last_next = init_last_reg;
    sel_n_next     = sel_n_reg;
    we_n_next      = we_n_reg;
    oe_n_next      = oe_n_reg;
    doe_next       = doe_reg;
    dbit_next      = dbit_reg;
    ready_next     = ready_reg;
    rsp_next       = 1'b0;
    owned_next     = owned_reg;
    case (state_reg)
      dpsem_pkg::DPSEM_IDLE: begin
        ready_next = 1'b1;
        if (cmd_valid && ready_reg) begin
          ready_next     = 1'b0;
          op_next        = cmd_op;
          // Init sweeps every token from index zero
          idx_next       = (cmd_op == dpsem_pkg::DPSEM_OP_INIT) ? '0 : cmd_index; // R16
          init_last_next = 1'b0;
          sel_n_next     = 1'b0; // R3 R17
          cnt_next       = cyc(`DPSEM_SETUP_CYC);
          if (cmd_op == dpsem_pkg::DPSEM_OP_POLL) begin
            state_next = dpsem_pkg::DPSEM_RD_SETUP;
          end else begin
            // Write always precedes the read-back of a claim
            state_next = dpsem_pkg::DPSEM_WR_SETUP; // R13
            doe_next   = 1'b1;
            dbit_next  = token_wr_value(cmd_op); // R2 R5
          end
        end
      end
      dpsem_pkg::DPSEM_WR_SETUP: begin
        if (cnt_reg == '0) begin
          we_n_next  = 1'b0;
          cnt_next   = cyc(`DPSEM_STROBE_CYC);
          state_next = dpsem_pkg::DPSEM_WR_STROBE;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      dpsem_pkg::DPSEM_WR_STROBE: begin
        if (cnt_reg == '0) begin
          we_n_next  = 1'b1;
          cnt_next   = cyc(`DPSEM_GAP_CYC);
          state_next = dpsem_pkg::DPSEM_WR_GAP;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      dpsem_pkg::DPSEM_WR_GAP: begin
        // Select and data outlast the strobe a cycle, so the write never sees data float
        sel_n_next = 1'b1;
        doe_next   = 1'b0;
        if (cnt_reg != '0) begin
          cnt_next = cnt_reg - 1'b1;
        end else if (op_reg == dpsem_pkg::DPSEM_OP_INIT && !init_last_reg) begin
          idx_next       = idx_reg + 1'b1;
          init_last_next = (idx_reg == `DPSEM_IDX_W'(`DPSEM_TOKEN_COUNT - 2));
          sel_n_next     = 1'b0;
          doe_next       = 1'b1;
          cnt_next       = cyc(`DPSEM_SETUP_CYC);
          state_next     = dpsem_pkg::DPSEM_WR_SETUP; // R16
        end else if (op_reg == dpsem_pkg::DPSEM_OP_CLAIM) begin
          sel_n_next = 1'b0;
          cnt_next   = cyc(`DPSEM_SETUP_CYC);
          state_next = dpsem_pkg::DPSEM_RD_SETUP; // R13
        end else begin
          owned_next = 1'b0;
          rsp_next   = 1'b1;
          state_next = dpsem_pkg::DPSEM_DONE;
        end
      end
      dpsem_pkg::DPSEM_RD_SETUP: begin
        if (cnt_reg == '0) begin
          oe_n_next  = 1'b0; // R11
          cnt_next   = cyc(`DPSEM_STROBE_CYC + 2);
          state_next = dpsem_pkg::DPSEM_RD_STROBE;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      dpsem_pkg::DPSEM_RD_STROBE: begin
        if (cnt_reg == '0) begin
          // Flag is spread over all bits; bit zero is enough
          owned_next = ~rd_sync[`DPSEM_TOKEN_BIT]; // R6 R8 R10
          oe_n_next  = 1'b1;
          // Both strobes dropped so the next poll sees a fresh value
          sel_n_next = 1'b1; // R12
          cnt_next   = cyc(`DPSEM_GAP_CYC);
          state_next = dpsem_pkg::DPSEM_RD_GAP;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      dpsem_pkg::DPSEM_RD_GAP: begin
        if (cnt_reg == '0) begin
          rsp_next   = 1'b1; // R14
          state_next = dpsem_pkg::DPSEM_DONE;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      dpsem_pkg::DPSEM_DONE: begin
        ready_next = 1'b1;
        state_next = dpsem_pkg::DPSEM_IDLE;
      end
      default: begin
        state_next = dpsem_pkg::DPSEM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg     <= dpsem_pkg::DPSEM_IDLE;
      op_reg        <= dpsem_pkg::DPSEM_OP_INIT;
      cnt_reg       <= '0;
      idx_reg       <= '0;
      init_last_reg <= 1'b0;
      sel_n_reg     <= 1'b1;
      we_n_reg      <= 1'b1;
      oe_n_reg      <= 1'b1;
      doe_reg       <= 1'b0;
      dbit_reg      <= 1'b1;
      ready_reg     <= 1'b0;
      rsp_reg       <= 1'b0;
      owned_reg     <= 1'b0;
    end else begin
      state_reg     <= state_next;
      op_reg        <= op_next;
      cnt_reg       <= cnt_next;
      idx_reg       <= idx_next;
      init_last_reg <= init_last_next;
      sel_n_reg     <= sel_n_next;
      we_n_reg      <= we_n_next;
      oe_n_reg      <= oe_n_next;
      doe_reg       <= doe_next;
      dbit_reg      <= dbit_next;
      ready_reg     <= ready_next;
      rsp_reg       <= rsp_next;
      owned_reg     <= owned_next;
    end
  end

  assign cmd_ready            = ready_reg;
  assign rsp_valid            = rsp_reg;
  assign rsp_owned            = owned_reg;
  assign token_space_select_n = sel_n_reg;
  assign mem_enable_n         = 1'b1; // R17
  assign write_n              = we_n_reg;
  assign out_enable_n         = oe_n_reg;
  assign token_index          = idx_reg; // R4
  assign data_out             = {{(`DPSEM_DATA_W-1){1'b1}}, dbit_reg}; // R5
  assign data_oe              = doe_reg;

  write_needs_select_a: assert property (@(posedge clk) disable iff (!rst_b)
    !we_n_reg |-> !sel_n_reg && doe_reg) else $error("write strobe without select or data"); // R3

  no_bus_fight_a: assert property (@(posedge clk) disable iff (!rst_b)
    !(doe_reg && !oe_n_reg)) else $error("data driven while device outputs enabled"); // R3

  claim_writes_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    !we_n_reg && op_reg == dpsem_pkg::DPSEM_OP_CLAIM |-> !dbit_reg) else $error("claim not zero"); // R2

  release_writes_one_a: assert property (@(posedge clk) disable iff (!rst_b)
    !we_n_reg && op_reg != dpsem_pkg::DPSEM_OP_CLAIM |-> dbit_reg) else $error("release not one"); // R2

  read_after_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(oe_n_reg) && op_reg == dpsem_pkg::DPSEM_OP_CLAIM |-> state_reg == dpsem_pkg::DPSEM_RD_STROBE)
    else $error("claim read in wrong phase"); // R13

  strobes_drop_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(oe_n_reg) |-> sel_n_reg) else $error("select held across reads"); // R12

  owned_capture_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(oe_n_reg) |-> owned_reg == ~$past(rd_sync[0])) else $error("owned flag mismatch"); // R10

  init_sweep_a: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == dpsem_pkg::DPSEM_IDLE && cmd_valid && ready_reg && cmd_op == dpsem_pkg::DPSEM_OP_INIT
    |-> ##1 idx_reg == 3'h0) else $error("init not from index zero"); // R16
endmodule

// >>> dpsem_dev_model.sv
// Behavioural two-port semaphore device facing the controller
`timescale 1ns/1ps
module dpsem_dev_model (
  // Port zero pins
  input  wire logic       sel0_n,
  input  wire logic       ce0_n,
  input  wire logic       wr0_n,
  input  wire logic       oe0_n,
  input  wire logic [2:0] idx0,
  input  wire logic [7:0] d0,
  output logic      [7:0] q0,
  // Port one pins
  input  wire logic       sel1_n,
  input  wire logic       ce1_n,
  input  wire logic       wr1_n,
  input  wire logic       oe1_n,
  input  wire logic [2:0] idx1,
  input  wire logic [7:0] d1,
  output logic      [7:0] q1
);
  // Left unknown at power-up; nothing here frees them
  logic [7:0] req0;
  logic [7:0] req1;
  logic [1:0] own [8];
  logic       r0;
  logic       r1;

  // Owner 1 is port zero, 2 is port one, 0 free
  function automatic logic [1:0] arb(logic [1:0] o, logic a, logic b);
    if (o == 2'h1 && a === 1'b1) return (b === 1'b0) ? 2'h2 : 2'h0;
    if (o == 2'h2 && b === 1'b1) return (a === 1'b0) ? 2'h1 : 2'h0;
    if (o == 2'h1 || o == 2'h2) return o;
    if (a === 1'b0) return 2'h1;
    if (b === 1'b0) return 2'h2;
    return (a === 1'b1 && b === 1'b1) ? 2'h0 : 2'bxx;
  endfunction

  always @(sel0_n, ce0_n, wr0_n, idx0, d0, sel1_n, ce1_n, wr1_n, idx1, d1) begin
    if (!sel0_n && ce0_n && !wr0_n) req0[idx0] = d0[0];
    if (!sel1_n && ce1_n && !wr1_n) req1[idx1] = d1[0];
    for (int i = 0; i < 8; i++) own[i] = arb(own[i], req0[i], req1[i]);
  end

  // Frozen for the read so the other side cannot disturb it
  always @(negedge (sel0_n | oe0_n)) r0 = (own[idx0] == 2'h1) ? 1'b0 : 1'b1;
  always @(negedge (sel1_n | oe1_n)) r1 = (own[idx1] == 2'h2) ? 1'b0 : 1'b1;
  // Released bus shows the inverse so stale data never looks valid
  assign q0 = (!sel0_n && !oe0_n && wr0_n) ? {8{r0}} : {8{~r0}};
  assign q1 = (!sel1_n && !oe1_n && wr1_n) ? {8{r1}} : {8{~r1}};
endmodule

// >>> test_dual_port_semaphore_flags.sv
// Self-checking bench for the semaphore port controller
`timescale 1ns/1ps
`include "dpsem_cfg.svh"
module test_dual_port_semaphore_flags;
  logic                 clk = 1'b0;
  logic                 rst_b = 1'b0;
  logic                 cmd_valid = 1'b0;
  dpsem_pkg::dpsem_op_t cmd_op = dpsem_pkg::DPSEM_OP_POLL;
  logic [2:0]           cmd_index = 3'h0;
  logic                 cmd_ready, rsp_valid, rsp_owned, sel_n, ce_n, wr_n, oe_n, data_oe;
  logic [2:0]           idx;
  logic [7:0]           dout, din, q1;
  logic                 sel1_n = 1'b1, wr1_n = 1'b1, oe1_n = 1'b1;
  logic [2:0]           idx1 = 3'h0;
  logic [7:0]           d1 = 8'hff;
  int                   num_errors = 0;
  int                   comparisons = 0;
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, a, b); end end

  always #5 clk = ~clk;

  dpsem_ctrl dut (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_index(cmd_index),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_owned(rsp_owned), .token_space_select_n(sel_n),
    .mem_enable_n(ce_n), .write_n(wr_n), .out_enable_n(oe_n), .token_index(idx), .data_out(dout),
    .data_oe(data_oe), .data_in(din));
  dpsem_dev_model device (.sel0_n(sel_n), .ce0_n(ce_n), .wr0_n(wr_n), .oe0_n(oe_n), .idx0(idx),
    .d0(data_oe ? dout : 8'hzz), .q0(din), .sel1_n(sel1_n), .ce1_n(1'b1), .wr1_n(wr1_n),
    .oe1_n(oe1_n), .idx1(idx1), .d1(d1), .q1(q1));

  task automatic final_report;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n == 200) begin
      num_errors++;
      final_report();
    end
  endtask

  task automatic run(input dpsem_pkg::dpsem_op_t op, input logic [2:0] i, input logic exp);
    wait_hi(cmd_ready);
    cmd_op = op;
    cmd_index = i;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    wait_hi(rsp_valid);
    `CHK(rsp_owned, exp)
    `CHK(ce_n, 1'b1)
    @(negedge clk);
  endtask

  task automatic bwr(input logic [2:0] i, input logic v);
    sel1_n = 1'b0;
    idx1 = i;
    d1 = {7'h7f, v};
    repeat (2) @(negedge clk);
    wr1_n = 1'b0;
    repeat (3) @(negedge clk);
    wr1_n = 1'b1;
    @(negedge clk);
    sel1_n = 1'b1;
    d1 = {8{~v}};
    @(negedge clk);
  endtask

  // Select and enable drop after every read so each one samples afresh
  task automatic brd(input logic [2:0] i, input logic [7:0] exp);
    // Index settles before the strobes so the latch picks the right token
    idx1 = i;
    sel1_n = 1'b0;
    oe1_n = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(q1, exp)
    oe1_n = 1'b1;
    sel1_n = 1'b1;
    @(negedge clk);
  endtask

  task automatic sc_init;
    run(dpsem_pkg::DPSEM_OP_INIT, 3'h0, 1'b0);
    for (int i = 0; i < 8; i++) bwr(3'(i), 1'b1);
    for (int i = 0; i < 8; i++) run(dpsem_pkg::DPSEM_OP_POLL, 3'(i), 1'b0);
    for (int i = 0; i < 8; i++) brd(3'(i), 8'hff);
  endtask

  task automatic sc_pending;
    run(dpsem_pkg::DPSEM_OP_CLAIM, 3'h3, 1'b1);
    brd(3'h3, 8'hff);
    bwr(3'h3, 1'b0);
    brd(3'h3, 8'hff);
    run(dpsem_pkg::DPSEM_OP_POLL, 3'h3, 1'b1);
    run(dpsem_pkg::DPSEM_OP_RELEASE, 3'h3, 1'b0);
    brd(3'h3, 8'h00);
    run(dpsem_pkg::DPSEM_OP_POLL, 3'h3, 1'b0);
    bwr(3'h3, 1'b1);
    run(dpsem_pkg::DPSEM_OP_CLAIM, 3'h3, 1'b1);
    run(dpsem_pkg::DPSEM_OP_RELEASE, 3'h3, 1'b0);
  endtask

  // Odd tokens go to the controller, even ones to the far port
  task automatic sc_index;
    for (int i = 0; i < 8; i++)
      if (i % 2 == 1) run(dpsem_pkg::DPSEM_OP_CLAIM, 3'(i), 1'b1);
      else bwr(3'(i), 1'b0);
    for (int i = 0; i < 8; i++) brd(3'(i), (i % 2 == 1) ? 8'hff : 8'h00);
    for (int i = 0; i < 8; i++) run(dpsem_pkg::DPSEM_OP_POLL, 3'(i), 1'((i % 2 == 1)));
    for (int i = 0; i < 8; i++)
      if (i % 2 == 1) run(dpsem_pkg::DPSEM_OP_RELEASE, 3'(i), 1'b0);
      else bwr(3'(i), 1'b1);
  endtask

  task automatic sc_withdraw;
    bwr(3'h5, 1'b0);
    run(dpsem_pkg::DPSEM_OP_CLAIM, 3'h5, 1'b0);
    run(dpsem_pkg::DPSEM_OP_RELEASE, 3'h5, 1'b0);
    bwr(3'h5, 1'b1);
    run(dpsem_pkg::DPSEM_OP_POLL, 3'h5, 1'b0);
    brd(3'h5, 8'hff);
  endtask

  // Token ownership lives in the device and outlasts a controller reset
  task automatic sc_reset;
    run(dpsem_pkg::DPSEM_OP_CLAIM, 3'h6, 1'b1);
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    run(dpsem_pkg::DPSEM_OP_POLL, 3'h6, 1'b1);
    brd(3'h6, 8'hff);
    run(dpsem_pkg::DPSEM_OP_RELEASE, 3'h6, 1'b0);
  endtask

  initial begin
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    sc_init();
    sc_pending();
    sc_index();
    sc_withdraw();
    sc_reset();
    final_report();
  end
endmodule
